// ---- src/sioc_stage_cfg.sv ----
// Purpose: Twelve-stage input routing and offset configuration behind an AXI4-Lite slave
// Assumes: stage_sel comes from a sequencer on aclk; ce freezes everything while low
// Notes: Stage words read zero after reset; software still writes them all first
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module sioc_stage_cfg
    import sioc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] stage_sel,
    output logic [5:0] route_neg,
    output logic [5:0] route_pos,
    output logic [5:0] route_bias,
    output logic meas_se_pos,
    output logic meas_se_neg,
    output logic meas_diff,
    output logic [5:0] negative_offset_code,
    output logic [14:0] neg_offset_ff,
    output logic neg_offset_to_neg,
    output logic neg_offset_to_pos,
    output logic [5:0] positive_offset_code,
    output logic [14:0] pos_offset_ff,
    output logic pos_offset_to_pos,
    output logic pos_offset_to_neg
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_have;
        logic [9:0] aw_idx;
        logic w_have;
        logic [15:0] w_data;
        logic [1:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        sioc_rd_t rd;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic mtype_err;
        logic [3:0] live_stage;
    } sioc_bus_t;

    localparam sioc_bus_t SIOC_BUS_RESET = '{
        awready: 1'b1, wready: 1'b1, arready: 1'b1, rd: RD_IDLE, default: '0};

    sioc_bus_t r;
    sioc_bus_t n;
    sioc_map_t wmap;
    sioc_map_t rmap;
    logic do_wr;
    logic mem_we;
    logic [4:0] mem_a_addr;
    logic [15:0] mem_a_data;
    logic [15:0] conn_live;
    logic [15:0] afe_live;

    // Bus unprotected; AWPROT and ARPROT carry no meaning here
    assign wmap = sioc_map(r.aw_idx);
    assign rmap = sioc_map(s_axi_araddr[11:2]);
    assign do_wr = r.aw_have && r.w_have && !r.bvalid;
    assign mem_we = do_wr && wmap.hit;
    assign mem_a_addr = rmap.addr;

    // Bus slave next state; address and data may arrive in either order
    always_comb
    begin
        n = r;
        if (s_axi_awvalid && r.awready)
        begin
            n.aw_have = 1'b1;
            n.aw_idx = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && r.wready)
        begin
            n.w_have = 1'b1;
            n.w_data = s_axi_wdata[15:0];
            n.w_strb = s_axi_wstrb[1:0];
        end
        if (r.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
        end
        if (do_wr)
        begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = (wmap.hit || r.aw_idx == SIOC_IDX_STATUS) ? SIOC_RESP_OKAY
                : SIOC_RESP_SLVERR;
            // Write one to clear the forbidden-type flag
            if (r.aw_idx == SIOC_IDX_STATUS && r.w_strb[0] && r.w_data[0])
            begin
                n.mtype_err = 1'b0;
            end
            // Catch a forbidden type code; placed after the clear so set wins
            if (wmap.hit && !wmap.addr[0] && r.w_strb[1]
                && r.w_data[SIOC_MTYPE_LSB +: 2] == SIOC_MT_FORBIDDEN)
            begin
                n.mtype_err = 1'b1;
            end
        end
        // One outstanding write: hold ready low until the response is gone
        n.awready = !n.aw_have && !n.bvalid;
        n.wready = !n.w_have && !n.bvalid;
        n.live_stage = stage_sel;

        // Read side: store reads take one extra cycle through the port register
        case (r.rd)
            RD_IDLE:
            begin
                if (s_axi_arvalid && r.arready)
                begin
                    n.arready = 1'b0;
                    if (rmap.hit)
                    begin
                        n.rd = RD_WAIT;
                    end
                    else
                    begin
                        n.rd = RD_RESP;
                        n.rvalid = 1'b1;
                        if (s_axi_araddr[11:2] == SIOC_IDX_STATUS)
                        begin
                            n.rdata = {27'h0, r.live_stage, r.mtype_err};
                            n.rresp = SIOC_RESP_OKAY;
                        end
                        else
                        begin
                            n.rdata = 32'h0;
                            n.rresp = SIOC_RESP_SLVERR;
                        end
                    end
                end
            end
            RD_WAIT:
            begin
                n.rvalid = 1'b1;
                n.rdata = {16'h0, mem_a_data};
                n.rresp = SIOC_RESP_OKAY;
                n.rd = RD_RESP;
            end
            RD_RESP:
            begin
                if (s_axi_rready)
                begin
                    n.rvalid = 1'b0;
                    n.arready = 1'b1;
                    n.rd = RD_IDLE;
                end
            end
            default:
            begin
                n.rd = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r <= SIOC_BUS_RESET;
        end
        else if (ce)
        begin
            r <= n;
        end
    end

    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;

    // Separate word pairs per stage; port B fetches the live stage's upper connection word
    sioc_word_mem #(
        .DW(SIOC_WORD_W),
        .DEPTH(2 * SIOC_NUM_STAGES),
        .AW(5)
    ) u_conn_mem (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .we(mem_we),
        .wbe(r.w_strb),
        .waddr(wmap.addr),
        .wdata(r.w_data),
        .a_addr(mem_a_addr),
        .a_data(mem_a_data),
        .b_addr({stage_sel, 1'b0}),
        .b_data(conn_live)
    );

    // Offset word fetched in the same cycle as the upper word; reusing port A
    // would stall reads, so the word pair is kept in a twin copy instead
    sioc_word_mem #(
        .DW(SIOC_WORD_W),
        .DEPTH(2 * SIOC_NUM_STAGES),
        .AW(5)
    ) u_afe_mem (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .we(mem_we),
        .wbe(r.w_strb),
        .waddr(wmap.addr),
        .wdata(r.w_data),
        .a_addr({stage_sel, 1'b1}),
        .a_data(afe_live),
        // Port B of the twin is spare
        .b_addr(5'h0),
        .b_data()
    );

    // Fields are decoded from whatever software wrote; the store clears to zero
    sioc_stage_decode u_decode (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .conn_word(conn_live),
        .afe_word(afe_live),
        .route_neg(route_neg),
        .route_pos(route_pos),
        .route_bias(route_bias),
        .meas_se_pos(meas_se_pos),
        .meas_se_neg(meas_se_neg),
        .meas_diff(meas_diff),
        .negative_offset_code(negative_offset_code),
        .neg_offset_ff(neg_offset_ff),
        .neg_offset_to_neg(neg_offset_to_neg),
        .neg_offset_to_pos(neg_offset_to_pos),
        .positive_offset_code(positive_offset_code),
        .pos_offset_ff(pos_offset_ff),
        .pos_offset_to_pos(pos_offset_to_pos),
        .pos_offset_to_neg(pos_offset_to_neg)
    );

    sequence s_rd_taken_hit;
        ce && s_axi_arvalid && s_axi_arready && rmap.hit;
    endsequence

    sequence s_rd_data_out;
        ce ##1 ce ##1 s_axi_rvalid;
    endsequence

    a_rd_latency: assert property (@(posedge aclk) disable iff (!aresetn)
        s_rd_taken_hit |-> s_rd_data_out)
        else $error("stage word read answer not two cycles after address");
    a_wr_stage_addr: assert property (@(posedge aclk) disable iff (!aresetn)
        mem_we |-> wmap.addr[4:1] < 4'd12 && wmap.addr[4:1] == 4'(r.aw_idx[9:3] - 7'h10))
        else $error("write landed in the wrong stage slot");
    a_mtype_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && mem_we && !wmap.addr[0] && r.w_strb[1] && r.w_data[13:12] == 2'h0
        |=> r.mtype_err)
        else $error("forbidden measurement type not flagged");
    a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before accept");
endmodule

// ---- src/sioc_pkg.sv ----
// Purpose: Shared constants, types and address decode for the stage input/offset config block
// Assumes: 32-bit AXI4-Lite data, word indices scaled by four into byte addresses
// Notes: Printed offsets are word indices; byte address is four times the index
package sioc_pkg;

    // Register map, as word indices
    localparam logic [9:0] SIOC_IDX_BASE = 10'h080;
    localparam logic [9:0] SIOC_IDX_STATUS = 10'h0ff;
    localparam logic [2:0] SIOC_SUB_UPPER = 3'h1;
    localparam logic [2:0] SIOC_SUB_AFE = 3'h2;
    localparam int SIOC_NUM_STAGES = 12;
    localparam int SIOC_WORD_W = 16;
    localparam int SIOC_ROUTED_INPUTS = 6;

    // Upper connection word fields
    localparam int SIOC_MTYPE_LSB = 12;
    localparam int SIOC_NEG_OFF_BIT = 14;
    localparam int SIOC_POS_OFF_BIT = 15;

    // Offset word fields
    localparam int SIOC_NEG_CODE_LSB = 0;
    localparam int SIOC_NEG_STEER_BIT = 7;
    localparam int SIOC_POS_CODE_LSB = 8;
    localparam int SIOC_POS_STEER_BIT = 15;
    localparam int SIOC_CODE_W = 6;

    // Offset weight, femtofarads per count
    localparam logic [8:0] SIOC_OFFSET_LSB_FF = 9'h140;

    // Routing and measurement codes
    localparam logic [1:0] SIOC_ROUTE_NONE = 2'h0;
    localparam logic [1:0] SIOC_ROUTE_NEG = 2'h1;
    localparam logic [1:0] SIOC_ROUTE_POS = 2'h2;
    localparam logic [1:0] SIOC_ROUTE_BIAS = 2'h3;
    localparam logic [1:0] SIOC_MT_FORBIDDEN = 2'h0;
    localparam logic [1:0] SIOC_MT_SE_POS = 2'h1;
    localparam logic [1:0] SIOC_MT_SE_NEG = 2'h2;
    localparam logic [1:0] SIOC_MT_DIFF = 2'h3;

    // Bus answers
    localparam logic [1:0] SIOC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SIOC_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} sioc_rd_t;

    typedef struct packed {
        logic hit;
        logic [4:0] addr;
    } sioc_map_t;

    // Word index to store address: stage times two plus word select
    function automatic sioc_map_t sioc_map(input logic [9:0] idx);
        logic [9:0] off;
        sioc_map_t m;
        off = idx - SIOC_IDX_BASE;
        m.hit = (idx >= SIOC_IDX_BASE) && (off[9:3] < 7'(SIOC_NUM_STAGES))
            && ((off[2:0] == SIOC_SUB_UPPER) || (off[2:0] == SIOC_SUB_AFE));
        m.addr = {off[6:3], off[2:0] == SIOC_SUB_AFE};
        return m;
    endfunction

endpackage

// ---- src/sioc_word_mem.sv ----
// Purpose: Per-stage word store, one write port and two registered read ports
// Assumes: Software writes every word before its stage is used
// Notes: Read during write returns the old word
`timescale 1ns/1ps
module sioc_word_mem #(
    parameter int DW = 16,
    parameter int DEPTH = 24,
    parameter int AW = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic we,
    input wire logic [1:0] wbe,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] a_addr,
    output logic [DW-1:0] a_data,
    input wire logic [AW-1:0] b_addr,
    output logic [DW-1:0] b_data
);
    logic [DW-1:0] mem [DEPTH];

    // Cleared by reset so the live decode never sees unknown words; costs a reset per bit
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem[i] <= '0;
            end
        end
        else
        begin
            if (ce && we && wbe[0])
            begin
                mem[waddr][7:0] <= wdata[7:0];
            end
            if (ce && we && wbe[1])
            begin
                mem[waddr][DW-1:8] <= wdata[DW-1:8];
            end
        end
    end

    // Registered read ports
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            a_data <= '0;
            b_data <= '0;
        end
        else if (ce)
        begin
            a_data <= mem[a_addr];
            b_data <= mem[b_addr];
        end
    end
endmodule

// ---- src/sioc_stage_decode.sv ----
// Purpose: Turn one stage's two words into switch-matrix and offset controls
// Assumes: Words arrive from the store's registered port
// Notes: All outputs registered; reset state is everything disconnected
`timescale 1ns/1ps
module sioc_stage_decode
    import sioc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [15:0] conn_word,
    input wire logic [15:0] afe_word,
    output logic [5:0] route_neg,
    output logic [5:0] route_pos,
    output logic [5:0] route_bias,
    output logic meas_se_pos,
    output logic meas_se_neg,
    output logic meas_diff,
    output logic [5:0] negative_offset_code,
    output logic [14:0] neg_offset_ff,
    output logic neg_offset_to_neg,
    output logic neg_offset_to_pos,
    output logic [5:0] positive_offset_code,
    output logic [14:0] pos_offset_ff,
    output logic pos_offset_to_pos,
    output logic pos_offset_to_neg
);
    typedef struct packed {
        logic [5:0] rneg;
        logic [5:0] rpos;
        logic [5:0] rbias;
        logic se_pos;
        logic se_neg;
        logic diff;
        logic [5:0] ncode;
        logic [14:0] nff;
        logic n_neg;
        logic n_pos;
        logic [5:0] pcode;
        logic [14:0] pff;
        logic p_pos;
        logic p_neg;
    } sioc_dec_t;

    sioc_dec_t r;
    sioc_dec_t n;

    // Offset code to femtofarads
    function automatic logic [14:0] code_to_ff(input logic [5:0] code);
        return 15'(code) * 15'(SIOC_OFFSET_LSB_FF);
    endfunction

    // Field of sense input 7+i sits two bits per input from bit 0
    function automatic logic [1:0] route_of(input logic [15:0] w, input int i);
        return w[2*i +: 2];
    endfunction

    always_comb
    begin
        n = r;
        for (int i = 0; i < SIOC_ROUTED_INPUTS; i++)
        begin
            n.rneg[i] = route_of(conn_word, i) == SIOC_ROUTE_NEG;
            n.rpos[i] = route_of(conn_word, i) == SIOC_ROUTE_POS;
            n.rbias[i] = route_of(conn_word, i) == SIOC_ROUTE_BIAS;
        end
        // Forbidden code 00 selects no measurement at all
        n.se_pos = conn_word[SIOC_MTYPE_LSB +: 2] == SIOC_MT_SE_POS;
        n.se_neg = conn_word[SIOC_MTYPE_LSB +: 2] == SIOC_MT_SE_NEG;
        n.diff = conn_word[SIOC_MTYPE_LSB +: 2] == SIOC_MT_DIFF;
        n.ncode = afe_word[SIOC_NEG_CODE_LSB +: SIOC_CODE_W];
        n.nff = code_to_ff(n.ncode);
        n.pcode = afe_word[SIOC_POS_CODE_LSB +: SIOC_CODE_W];
        n.pff = code_to_ff(n.pcode);
        // Disable bit gates, steer bit picks the side
        n.n_neg = !conn_word[SIOC_NEG_OFF_BIT] && !afe_word[SIOC_NEG_STEER_BIT];
        n.n_pos = !conn_word[SIOC_NEG_OFF_BIT] && afe_word[SIOC_NEG_STEER_BIT];
        n.p_pos = !conn_word[SIOC_POS_OFF_BIT] && !afe_word[SIOC_POS_STEER_BIT];
        n.p_neg = !conn_word[SIOC_POS_OFF_BIT] && afe_word[SIOC_POS_STEER_BIT];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r <= '0;
        end
        else if (ce)
        begin
            r <= n;
        end
    end

    assign route_neg = r.rneg;
    assign route_pos = r.rpos;
    assign route_bias = r.rbias;
    assign meas_se_pos = r.se_pos;
    assign meas_se_neg = r.se_neg;
    assign meas_diff = r.diff;
    assign negative_offset_code = r.ncode;
    assign neg_offset_ff = r.nff;
    assign neg_offset_to_neg = r.n_neg;
    assign neg_offset_to_pos = r.n_pos;
    assign positive_offset_code = r.pcode;
    assign pos_offset_ff = r.pff;
    assign pos_offset_to_pos = r.p_pos;
    assign pos_offset_to_neg = r.p_neg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_in12_route: assert property (ce && conn_word[11:10] == 2'h1 |=> route_neg[5] && !route_pos[5])
        else $error("input 12 field not routed to negative side");
    a_in7_pos: assert property (ce && conn_word[1:0] == 2'h2 |=> route_pos[0] && !route_bias[0])
        else $error("input 7 code 10 not on positive side");
    a_none_route: assert property (ce && conn_word[3:2] == 2'h0 |=> !route_neg[1] && !route_pos[1] && !route_bias[1])
        else $error("code 00 left input 8 connected");
    a_mtype_onehot: assert property (ce |=> $onehot0({meas_se_pos, meas_se_neg, meas_diff})
        && (meas_se_neg == ($past(conn_word[13:12]) == 2'h2)))
        else $error("measurement type decode wrong");
    a_neg_gate: assert property (ce && conn_word[14] |=> !neg_offset_to_neg && !neg_offset_to_pos)
        else $error("negative offset applied while disabled");
    a_pos_gate: assert property (ce && !conn_word[15] && !afe_word[15] |=> pos_offset_to_pos)
        else $error("positive offset not applied to positive side");
    a_neg_weight: assert property (ce |=> neg_offset_ff == 15'($past(afe_word[5:0]) * 320))
        else $error("negative offset weight wrong");
    a_pos_code: assert property (ce |=> positive_offset_code == $past(afe_word[13:8]))
        else $error("positive offset code field wrong");
    a_neg_steer: assert property (ce && !conn_word[14] && afe_word[7] |=> neg_offset_to_pos && !neg_offset_to_neg)
        else $error("negative offset steer ignored");
endmodule

// ---- bench/sioc_host_model.sv ----
// Purpose: Host-side AXI4-Lite master that programs the stage words
// Assumes: One write or one read at a time, signals moved just after rising edges
// Notes: Released address lines carry inverted garbage so stale values never pass
`timescale 1ns/1ps
module sioc_host_model (
    input wire logic aclk,
    output logic [11:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    output logic bready,
    output logic [11:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    output logic rready
);
    // Idle bus at time zero
    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // Write: offer both halves, drop each when taken, wait for the answer
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
        logic ad, wd, bd;
        {ad, wd, bd} = 3'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0, d};
        wstrb <= s;
        {awvalid, wvalid, bready} <= 3'h7;
        while (!bd)
        begin
            @(posedge aclk);
            if (!ad && awready)
            begin
                ad = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (!wd && wready)
            begin
                wd = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~{16'h0, d};
            end
            if (bvalid)
            begin
                bd = 1'b1;
                bready <= 1'b0;
            end
        end
    endtask

    // Read: the bench monitor compares the data at the handshake edge
    task automatic rd(input logic [11:0] a);
        logic ad, rd_done;
        {ad, rd_done} = 2'h0;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        while (!rd_done)
        begin
            @(posedge aclk);
            if (!ad && arready)
            begin
                ad = 1'b1;
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (rvalid)
            begin
                rd_done = 1'b1;
                rready <= 1'b0;
            end
        end
    endtask
endmodule

// ---- bench/tb_stage_input_offset_config.sv ----
// Purpose: Self-checking bench for the stage routing and offset words
// Assumes: ce high except in the freeze test, prot ignored by the block
// Notes: Expected bus answers and decode vectors queue up; monitors pop them
`timescale 1ns/1ps
module tb_stage_input_offset_config;
    logic aclk = 1'b0, aresetn = 1'b0, probe = 1'b0, ce = 1'b1;
    logic [3:0] stage_sel = 4'h0;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [5:0] rn, rp, rb, nc, pc;
    logic [14:0] nff, pff;
    logic msp, msn, mdf, nn, np, pp, pn;
    logic [15:0] uw[12], ow[12];
    logic [33:0] bq[$];
    logic [66:0] dq[$];
    int num_errors = 0, n_compared = 0, cyc = 0;

    always #5 aclk = ~aclk;

    sioc_stage_cfg dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .stage_sel(stage_sel), .route_neg(rn), .route_pos(rp),
        .route_bias(rb), .meas_se_pos(msp), .meas_se_neg(msn), .meas_diff(mdf),
        .negative_offset_code(nc), .neg_offset_ff(nff), .neg_offset_to_neg(nn),
        .neg_offset_to_pos(np), .positive_offset_code(pc), .pos_offset_ff(pff),
        .pos_offset_to_pos(pp), .pos_offset_to_neg(pn));

    sioc_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rvalid(rvalid), .rready(rready));

    task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Expected decode: routing bits, type flags, codes, femtofarads, steering
    function automatic logic [66:0] exp_dec(input logic [15:0] u, input logic [15:0] o);
        logic [5:0] n, p, b;
        for (int i = 0; i < 6; i++)
        begin
            n[i] = u[2*i +: 2] == 2'h1;
            p[i] = u[2*i +: 2] == 2'h2;
            b[i] = u[2*i +: 2] == 2'h3;
        end
        return {n, p, b, u[13:12] == 2'h1, u[13:12] == 2'h2, u[13:12] == 2'h3,
            o[5:0], 15'(o[5:0]) * 15'h140, !u[14] && !o[7], !u[14] && o[7],
            o[13:8], 15'(o[13:8]) * 15'h140, !u[15] && !o[15], !u[15] && o[15]};
    endfunction

    // Monitors: bus answers and live decode, each against the oldest note
    always @(posedge aclk)
    begin
        if (rvalid && rready)
            chk("read", {rresp, rdata}, bq.pop_front());
        if (bvalid && bready)
            chk("bresp", {bresp, 32'h0}, bq.pop_front());
        if (probe)
            chk("decode", {rn, rp, rb, msp, msn, mdf, nc, nff, nn, np, pc, pff, pp, pn},
                dq.pop_front());
    end

    task automatic wr_exp(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
        input logic [1:0] r);
        bq.push_back({r, 32'h0});
        host.wr(a, d, s);
    endtask

    task automatic rd_exp(input logic [11:0] a, input logic [33:0] e);
        bq.push_back(e);
        host.rd(a);
    endtask

    // Decode settles two edges after the select moves; one spare edge of margin
    task automatic probe_stage(input int s);
        stage_sel <= 4'(s);
        repeat (3) @(posedge aclk);
        dq.push_back(exp_dec(uw[s], ow[s]));
        probe <= 1'b1;
        @(posedge aclk);
        probe <= 1'b0;
    endtask

    task automatic print_verdict();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard well above the few hundred cycles the tests need
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    // Main sequence
    initial
    begin
        void'($urandom(87352));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int s = 0; s < 12; s++)
        begin
            uw[s] = 16'($urandom);
            ow[s] = 16'($urandom);
            if (s == 0)
                uw[s][11:0] = 12'h9e4;
            if (s < 3)
                uw[s][13:12] = 2'(s + 1);
            if (uw[s][13:12] == 2'h0)
                uw[s][13:12] = 2'h3;
            ow[s][6] = 1'b0;
            ow[s][14] = 1'b0;
            wr_exp(12'(12'h204 + 32 * s), uw[s], 4'h3, 2'h0);
            wr_exp(12'(12'h208 + 32 * s), ow[s], 4'h3, 2'h0);
        end
        for (int s = 0; s < 12; s++)
        begin
            rd_exp(12'(12'h204 + 32 * s), {18'h0, uw[s]});
            rd_exp(12'(12'h208 + 32 * s), {18'h0, ow[s]});
            probe_stage(s);
        end
        $display("test stages done");
        // Byte strobes keep the other byte; top positive code is a boundary
        wr_exp(12'h204, 16'hffff, 4'h1, 2'h0);
        uw[0][7:0] = 8'hff;
        wr_exp(12'h228, 16'h3f00, 4'h2, 2'h0);
        ow[1][15:8] = 8'h3f;
        rd_exp(12'h204, {18'h0, uw[0]});
        probe_stage(0);
        probe_stage(1);
        // Clock enable low: select moves but the decode must stay on stage 1
        ce <= 1'b0;
        stage_sel <= 4'h0;
        repeat (3) @(posedge aclk);
        dq.push_back(exp_dec(uw[1], ow[1]));
        probe <= 1'b1;
        @(posedge aclk);
        {probe, ce} <= 2'h1;
        $display("test strobes done");
        // Forbidden type 00 raises the sticky flag; writing one clears it
        wr_exp(12'h244, 16'h0, 4'h3, 2'h0);
        rd_exp(12'h3fc, {29'h0, stage_sel, 1'b1});
        wr_exp(12'h3fc, 16'h1, 4'h1, 2'h0);
        rd_exp(12'h3fc, {29'h0, stage_sel, 1'b0});
        $display("test status done");
        // Outside the block's words: refused and nothing stored
        wr_exp(12'h200, 16'h1234, 4'h3, 2'h2);
        wr_exp(12'h384, 16'h1234, 4'h3, 2'h2);
        rd_exp(12'h200, {2'h2, 32'h0});
        rd_exp(12'h384, {2'h2, 32'h0});
        rd_exp(12'h204, {18'h0, uw[0]});
        $display("test unmapped done");
        print_verdict();
    end
endmodule
